/* hw/tc8_timer.sv */
module tc8_timer (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic sleep_req,
   input wire logic external_count_input,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq
);

   tc8_pkg::tc8_state_s r_ff;
   tc8_pkg::tc8_state_s nxt_r;
   logic hready_ff;
   logic hresp_ff;

   // ****************************************
   // helpers
   // ****************************************

   // mask of prescaler bits that must all be set for one output pulse
   function automatic logic [7:0] div_mask(input logic [2:0] rate);
      logic [8:0] m;
      m = (9'h002 << rate) - 9'h001;
      return m[7:0];
   endfunction

   // one byte of register state widened to the bus word
   function automatic logic [31:0] word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   logic addr_phase;
   logic wr_count;
   logic ext_edge;
   logic src_tick;
   logic pre_tick;
   logic inc_now;
   logic ovf_now;
   logic clr_req;

   // ****************************************
   // next state
   // ****************************************

   always_comb begin
      nxt_r = r_ff;
      addr_phase = hsel && htrans[tc8_pkg::HTRANS_ACT] && hready;
      wr_count = r_ff.wr_pend && (r_ff.wr_addr == tc8_pkg::OFS_COUNT);
      // pin synchroniser; only the later stages feed the edge detector
      nxt_r.pin_s1 = external_count_input;
      nxt_r.pin_s2 = r_ff.pin_s1;
      nxt_r.pin_s3 = r_ff.pin_s2;
      if (r_ff.opt.source_edge_select) begin
         ext_edge = !r_ff.pin_s2 && r_ff.pin_s3;
      end else begin
         ext_edge = r_ff.pin_s2 && !r_ff.pin_s3;
      end
      // source select: instruction cycle or external edge
      src_tick = r_ff.opt.clock_source_select ? ext_edge : 1'b1;
      src_tick = src_tick && !sleep_req;
      // prescaler in path unless bypassed
      pre_tick = 1'b0;
      if (r_ff.opt.prescaler_bypass) begin
         pre_tick = src_tick;
      end else if (src_tick) begin
         nxt_r.pre = r_ff.pre + 8'h01;
         if ((r_ff.pre & div_mask(r_ff.opt.prescale_rate)) == div_mask(r_ff.opt.prescale_rate)) begin
            pre_tick = 1'b1;
            nxt_r.pre = tc8_pkg::PRE_RST;
         end
      end
      inc_now = pre_tick && (r_ff.inhibit == tc8_pkg::INHIBIT_NONE);
      ovf_now = inc_now && (r_ff.count == tc8_pkg::COUNT_MAX);
      // inhibit window counts down in instruction cycles
      if (r_ff.inhibit != tc8_pkg::INHIBIT_NONE && !sleep_req) begin
         nxt_r.inhibit = r_ff.inhibit - 2'h1;
      end
      if (inc_now) begin
         nxt_r.count = r_ff.count + 8'h01;
      end
      // write data phase
      clr_req = 1'b0;
      if (r_ff.wr_pend) begin
         if (r_ff.wr_addr == tc8_pkg::OFS_COUNT) begin
            nxt_r.count = hwdata[7:0];
            nxt_r.inhibit = tc8_pkg::INHIBIT_CYCLES;
            nxt_r.pre = tc8_pkg::PRE_RST;
         end else if (r_ff.wr_addr == tc8_pkg::OFS_OPTION) begin
            nxt_r.opt = hwdata[5:0];
         end else if (r_ff.wr_addr == tc8_pkg::OFS_INTCTL) begin
            nxt_r.overflow_irq_enable = hwdata[tc8_pkg::INTCTL_IE];
            clr_req = !hwdata[tc8_pkg::INTCTL_IF];
         end else if (r_ff.wr_addr == tc8_pkg::OFS_CLEAR) begin
            clr_req = hwdata[tc8_pkg::EVT_OVF];
         end else if (r_ff.wr_addr == tc8_pkg::OFS_ENABLE) begin
            nxt_r.overflow_irq_enable = hwdata[tc8_pkg::EVT_OVF];
         end
      end
      // sticky flag, a new overflow beats a clear in the same cycle
      if (ovf_now) begin
         nxt_r.overflow_flag = 1'b1;
      end else if (clr_req) begin
         nxt_r.overflow_flag = 1'b0;
      end
      nxt_r.irq = nxt_r.overflow_flag && nxt_r.overflow_irq_enable;
      // address phase capture and read data
      nxt_r.wr_pend = addr_phase && hwrite;
      nxt_r.wr_addr = haddr[7:0];
      if (addr_phase && !hwrite) begin
         if (haddr[7:0] == tc8_pkg::OFS_COUNT) begin
            nxt_r.rdata = word(r_ff.count);
         end else if (haddr[7:0] == tc8_pkg::OFS_OPTION) begin
            nxt_r.rdata = word({2'h0, r_ff.opt});
         end else if (haddr[7:0] == tc8_pkg::OFS_INTCTL) begin
            nxt_r.rdata = word({2'h0, r_ff.overflow_irq_enable, 2'h0, r_ff.overflow_flag, 2'h0});
         end else if (haddr[7:0] == tc8_pkg::OFS_STATUS) begin
            nxt_r.rdata = word({7'h00, r_ff.overflow_flag});
         end else if (haddr[7:0] == tc8_pkg::OFS_ENABLE) begin
            nxt_r.rdata = word({7'h00, r_ff.overflow_irq_enable});
         end else begin
            nxt_r.rdata = 32'h00000000;
         end
      end
   end

   // ****************************************
   // state register
   // ****************************************

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         r_ff <= '0;
         r_ff.count <= tc8_pkg::COUNT_RST;
         r_ff.opt <= tc8_pkg::OPTION_RST;
         r_ff.pre <= tc8_pkg::PRE_RST;
         r_ff.inhibit <= tc8_pkg::INHIBIT_NONE;
         hready_ff <= 1'b1;
         hresp_ff <= tc8_pkg::HRESP_OKAY;
      end else begin
         r_ff <= nxt_r;
         hready_ff <= 1'b1;
         hresp_ff <= tc8_pkg::HRESP_OKAY;
      end
   end

   // outputs straight from flops
   assign hreadyout = hready_ff;
   assign hresp = hresp_ff;
   assign hrdata = r_ff.rdata;
   assign irq = r_ff.irq;

   // ****************************************
   // checks
   // ****************************************

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic free_run;
   assign free_run = !r_ff.opt.clock_source_select && r_ff.opt.prescaler_bypass && !sleep_req;

   sequence s_load;
      r_ff.count == $past(hwdata[7:0]);
   endsequence

   sequence s_hold;
      ##1 $stable(r_ff.count) ##1 $stable(r_ff.count);
   endsequence

   a_write_inhibit: assert property (wr_count |=> s_load and (s_load ##0 s_hold))
      else $error("count moved inside inhibit window");

   a_timer_step: assert property (free_run && r_ff.inhibit == tc8_pkg::INHIBIT_NONE && !r_ff.wr_pend
      |=> r_ff.count == $past(r_ff.count) + 8'h01)
      else $error("timer did not advance");

   a_ext_edge: assert property (r_ff.opt.clock_source_select && r_ff.opt.prescaler_bypass && !sleep_req
      && r_ff.inhibit == tc8_pkg::INHIBIT_NONE && !r_ff.wr_pend && !ext_edge
      |=> $stable(r_ff.count))
      else $error("counter moved without an edge");

   a_ovf_set: assert property (ovf_now |=> r_ff.overflow_flag && r_ff.count == 8'h00)
      else $error("rollover did not set flag");

   a_flag_sticky: assert property (r_ff.overflow_flag && !clr_req |=> r_ff.overflow_flag)
      else $error("flag cleared without software");

   a_irq_gate: assert property (##1 irq == (r_ff.overflow_flag && r_ff.overflow_irq_enable))
      else $error("interrupt not gated by enable");

   a_sleep_freeze: assert property (sleep_req && !r_ff.wr_pend |=> $stable(r_ff.count))
      else $error("count changed during sleep");

   a_pre_clear: assert property (wr_count |=> r_ff.pre == tc8_pkg::PRE_RST)
      else $error("prescaler not cleared by write");

   // ****************************************
   // count, prescaler, pin and bus guards
   // ****************************************

   // external edge path ready to count with nothing blocking it
   logic ext_run;
   assign ext_run = r_ff.opt.clock_source_select && r_ff.opt.prescaler_bypass && !sleep_req
      && r_ff.inhibit == tc8_pkg::INHIBIT_NONE && !wr_count;

   // one increment of the count since the previous cycle
   sequence s_step;
      r_ff.count == $past(r_ff.count) + 8'h01;
   endsequence

   // an enabled increment lands as exactly plus one
   a_inc_step: assert property (inc_now && !wr_count
      |=> s_step)
      else $error("count did not step by one");

   // with no increment and no write the count holds
   a_count_hold: assert property (!inc_now && !wr_count
      |=> $stable(r_ff.count))
      else $error("count moved without a tick");

   // a bypassed prescaler stays untouched
   a_pre_idle: assert property (r_ff.opt.prescaler_bypass && !wr_count
      |=> $stable(r_ff.pre))
      else $error("bypassed prescaler moved");

   // the prescaler restarts each time it fires
   a_pre_wrap: assert property (pre_tick && !r_ff.opt.prescaler_bypass && !wr_count
      |=> r_ff.pre == tc8_pkg::PRE_RST)
      else $error("prescaler did not restart");

   // sleep also freezes prescaler and inhibit window
   a_sleep_still: assert property (sleep_req && !wr_count
      |=> $stable(r_ff.pre) && $stable(r_ff.inhibit))
      else $error("prescaler or inhibit moved in sleep");

   // a count write opens the full inhibit window
   a_inhibit_load: assert property (wr_count
      |=> r_ff.inhibit == tc8_pkg::INHIBIT_CYCLES)
      else $error("inhibit window not opened");

   // the inhibit window shrinks by one per awake cycle
   a_inhibit_step: assert property (r_ff.inhibit != tc8_pkg::INHIBIT_NONE && !sleep_req && !wr_count
      |=> r_ff.inhibit == $past(r_ff.inhibit) - 2'h1)
      else $error("inhibit window did not count down");

   // a synchronised rising pin edge counts when rising is selected
   a_rise_count: assert property (ext_run && !r_ff.opt.source_edge_select && r_ff.pin_s2 && !r_ff.pin_s3
      |=> s_step)
      else $error("rising edge not counted");

   // a synchronised falling pin edge counts when falling is selected
   a_fall_count: assert property (ext_run && r_ff.opt.source_edge_select && !r_ff.pin_s2 && r_ff.pin_s3
      |=> s_step)
      else $error("falling edge not counted");

   // the pin reaches the edge detector two clocks late
   a_sync_delay: assert property (##2
      r_ff.pin_s2 == $past(external_count_input, 2))
      else $error("pin synchroniser delay wrong");

   // a clear with no overflow drops the flag
   a_flag_clear: assert property (clr_req && !ovf_now
      |=> !r_ff.overflow_flag)
      else $error("flag not cleared by software");

   // only a rollover can raise the flag
   a_flag_source: assert property (!r_ff.overflow_flag && !ovf_now
      |=> !r_ff.overflow_flag)
      else $error("flag set without rollover");

   // the interrupt never stands without its enable
   a_irq_mask: assert property (irq
      |-> r_ff.overflow_irq_enable)
      else $error("interrupt raised while disabled");

   // an enabled standing flag keeps the interrupt high
   a_irq_hold: assert property (r_ff.overflow_flag && r_ff.overflow_irq_enable && !clr_req && !r_ff.wr_pend
      |=> irq)
      else $error("interrupt dropped while flag stands");

   // the enable register takes the written bit
   a_enable_load: assert property (r_ff.wr_pend && r_ff.wr_addr == tc8_pkg::OFS_ENABLE
      |=> r_ff.overflow_irq_enable == $past(hwdata[tc8_pkg::EVT_OVF]))
      else $error("enable write lost");

   // option writes land in the source and prescaler fields
   a_opt_load: assert property (r_ff.wr_pend && r_ff.wr_addr == tc8_pkg::OFS_OPTION
      |=> r_ff.opt == $past(hwdata[5:0]))
      else $error("option write lost");

   // a count read returns the count seen at the address phase
   a_read_count: assert property (addr_phase && !hwrite && haddr[7:0] == tc8_pkg::OFS_COUNT
      |=> hrdata == {24'h000000, $past(r_ff.count)})
      else $error("count read data wrong");

endmodule

/* hw/tc8_pkg.sv */
package tc8_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_OPTION = 8'h04;
   localparam logic [7:0] OFS_INTCTL = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_CLEAR = 8'h10;
   localparam logic [7:0] OFS_ENABLE = 8'h14;

   // ****************************************
   // field positions
   // ****************************************
   localparam int INTCTL_IE = 5;
   localparam int INTCTL_IF = 2;
   localparam int EVT_OVF = 0;
   localparam int HTRANS_ACT = 1;

   // ****************************************
   // reset values and counts
   // ****************************************
   localparam logic [5:0] OPTION_RST = 6'h3f;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   localparam logic [7:0] PRE_RST = 8'h00;
   localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
   localparam logic [1:0] INHIBIT_NONE = 2'h0;
   localparam logic HRESP_OKAY = 1'b0;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic clock_source_select;
      logic source_edge_select;
      logic prescaler_bypass;
      logic [2:0] prescale_rate;
   } tc8_opt_s;

   typedef struct packed {
      logic [7:0] count;
      tc8_opt_s opt;
      logic overflow_irq_enable;
      logic overflow_flag;
      logic [1:0] inhibit;
      logic [7:0] pre;
      logic pin_s1;
      logic pin_s2;
      logic pin_s3;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] rdata;
      logic irq;
   } tc8_state_s;

endpackage

/* test/tc8_pin_model.sv */
module tc8_pin_model (
   input wire logic clk_sys,
   output logic external_count_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // the pin idles low until the bench asks for a level
   initial begin
      external_count_input = 1'b0;
   end
   // change just after an edge, then keep the level for two clocks
   task automatic set_level(input logic v);
      @(posedge clk_sys);
      external_count_input <= v;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule

/* test/tc8_timer_bench.sv */
module tc8_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, sys_rst, sleep_req, hsel, hwrite, hreadyout, hresp, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, v0, v1, v2;
   wire logic ext_pin;
   int mismatches, total_checks;

   tc8_pin_model pin_m (.clk_sys(clk_sys), .external_count_input(ext_pin));
   tc8_timer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .sleep_req(sleep_req),
      .external_count_input(ext_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // address phase held until hready is sampled high
   task automatic ap(input logic [7:0] a, input logic w);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
   endtask
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      ap(a, 1'b1);
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
   endtask
   task automatic br(input logic [7:0] a, output logic [31:0] d);
      ap(a, 1'b0);
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      d = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   // count advance over a window of gap+2 clocks
   task automatic meas(input logic [31:0] opt, input int gap, input logic [7:0] exp);
      bw(tc8_pkg::OFS_OPTION, opt);
      br(tc8_pkg::OFS_COUNT, v0);
      repeat (gap) @(posedge clk_sys);
      br(tc8_pkg::OFS_COUNT, v1);
      chk("count step", {24'h000000, v1[7:0] - v0[7:0]}, {24'h000000, exp});
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // free-running 100 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // cuts a hung run short
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      test_done;
   end
   // main sequence
   initial begin
      sys_rst = 1'b1;
      sleep_req = 1'b0;
      hsel = 1'b1;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      mismatches = 0;
      total_checks = 0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      br(tc8_pkg::OFS_COUNT, v0);
      chk("count reset", v0, 32'h0);
      // load near the top, then watch inhibit and rollover
      bw(tc8_pkg::OFS_OPTION, 32'h08);
      bw(tc8_pkg::OFS_COUNT, 32'hfe);
      br(tc8_pkg::OFS_COUNT, v0);
      chk("count load", v0, 32'hfe);
      br(tc8_pkg::OFS_COUNT, v0);
      chk("count inhibit", v0, 32'hfe);
      br(tc8_pkg::OFS_COUNT, v0);
      chk("count wrap", v0, 32'h0);
      bw(tc8_pkg::OFS_OPTION, 32'h28);
      br(tc8_pkg::OFS_STATUS, v0);
      chk("flag set", v0, 32'h1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      repeat (20) @(posedge clk_sys);
      br(tc8_pkg::OFS_STATUS, v0);
      chk("flag sticky", v0, 32'h1);
      bw(tc8_pkg::OFS_ENABLE, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk("irq on", {31'h0, irq}, 32'h1);
      br(tc8_pkg::OFS_INTCTL, v0);
      chk("intctl", v0, 32'h24);
      bw(tc8_pkg::OFS_CLEAR, 32'h1);
      br(tc8_pkg::OFS_STATUS, v0);
      chk("flag clear", v0, 32'h0);
      chk("irq off", {31'h0, irq}, 32'h0);
      // sleep freezes a running timer
      bw(tc8_pkg::OFS_OPTION, 32'h08);
      sleep_req <= 1'b1;
      br(tc8_pkg::OFS_COUNT, v0);
      repeat (20) @(posedge clk_sys);
      br(tc8_pkg::OFS_COUNT, v1);
      chk("sleep hold", v1, v0);
      sleep_req <= 1'b0;
      // every prescale rate, window of four increments, then bypass with a window of eight increments
      for (int r = 0; r < 8; r++) begin
         meas(32'(r), (4 << (r + 1)) - 2, 8'h04);
      end
      meas(32'h0f, 6, 8'h08);
      // a count write must drop a part-filled prescaler
      bw(tc8_pkg::OFS_OPTION, 32'h07);
      repeat (200) @(posedge clk_sys);
      bw(tc8_pkg::OFS_COUNT, 32'h10);
      repeat (248) @(posedge clk_sys);
      br(tc8_pkg::OFS_COUNT, v0);
      chk("pre clear", v0, 32'h10);
      // external pin, rising then falling edge selected
      for (int se = 0; se < 2; se++) begin
         bw(tc8_pkg::OFS_OPTION, (se == 1) ? 32'h38 : 32'h28);
         br(tc8_pkg::OFS_COUNT, v0);
         pin_m.set_level(1'b1);
         repeat (4) @(posedge clk_sys);
         br(tc8_pkg::OFS_COUNT, v1);
         chk("rise", v1 - v0, (se == 1) ? 32'h0 : 32'h1);
         pin_m.set_level(1'b0);
         repeat (4) @(posedge clk_sys);
         br(tc8_pkg::OFS_COUNT, v2);
         chk("fall", v2 - v1, (se == 1) ? 32'h1 : 32'h0);
      end
      br(8'h40, v0);
      chk("unmapped", v0, 32'h0);
      test_done;
   end
endmodule
